// ### core/cfg_pkg.sv
// package for the converter setup word decoder
// assumes one system clock domain plus a serial link clock domain
package cfg_pkg;

  // ==========================================================
  // word layout
  localparam int unsigned WORD_W      = 14;
  localparam int unsigned UPDATE_BIT  = 13;
  localparam int unsigned CHAN_LSB    = 7;
  localparam int unsigned CHAN_W      = 3;
  localparam int unsigned BW_BIT      = 6;
  localparam int unsigned REF_LSB     = 3;
  localparam int unsigned REF_W       = 3;
  localparam int unsigned SEQ_LSB     = 1;
  localparam int unsigned SEQ_W       = 2;
  localparam int unsigned RB_BIT      = 0;
  // value held after reset (word is undefined at power-up; this is
  // the all-ones preload, which the host could also shift in)
  localparam logic [13:0] WORD_RESET  = 14'h3fff;
  localparam logic [4:0]  BITCNT_ZERO = 5'h00;
  localparam logic [4:0]  BITCNT_FULL = 5'h0e;

  // ==========================================================
  // reference field codes
  typedef enum logic [2:0] {
    REF_INT_2V5    = 3'b000,
    REF_INT_4V096  = 3'b001,
    REF_EXT_TEMP   = 3'b010,
    REF_EXTBUF_TMP = 3'b011,
    REF_RSV_100    = 3'b100,
    REF_RSV_101    = 3'b101,
    REF_EXT        = 3'b110,
    REF_EXTBUF     = 3'b111
  } ref_code_t;

  // scan mode field codes
  typedef enum logic [1:0] {
    SCAN_OFF       = 2'b00,
    SCAN_UPDATE    = 2'b01,
    SCAN_WITH_TEMP = 2'b10,
    SCAN_NO_TEMP   = 2'b11
  } scan_mode_t;

  // decoded analog controls
  typedef struct packed {
    logic [2:0] channel_select_field;
    logic       full_bandwidth;
    logic       int_ref_en;
    logic       int_ref_4v096;
    logic       ref_buffer_en;
    logic       temp_sensor_en;
    logic       ref_code_reserved;
    logic       scan_en;
    logic       scan_temp;
    logic       scan_update_only;
    logic       setup_readback_en;
  } setup_ctrl_t;

endpackage : cfg_pkg

// ### core/adc_config_field_decoder.sv
// setup word receiver and field decoder for the converter
// assumes sclk runs only during host access; eoc is a one-cycle
// pulse on clk marking end of conversion
//
// Operation
// - bit 6 high gives full filter bandwidth, low gives quarter.
// - reference codes 000 and 001 enable internal 2.5 V / 4.096 V.
// - codes 010,011,110,111 pick external reference, buffer, sensor.
// - bits 2:1 pick off, update-only, scan with or without sensor.
// - bit 0 low appends the setup word after the result on readout.
// - bits 9:7 are a plain binary channel number 0 to 7.
// - the word shifts in msb first on sclk rising; top bit 1 applies.
// - the word applies at end of conversion; partial words drop.
`timescale 1ns/1ps
module adc_config_field_decoder (
  // system clock and reset
  input  wire logic                 clk,
  input  wire logic                 arst_n,
  // serial link, own clock domain
  input  wire logic                 sclk,
  input  wire logic                 cs_n,
  input  wire logic                 din,
  // conversion timing, clk domain
  input  wire logic                 eoc,
  input  wire logic [13:0]          result,
  // decoded setup
  output logic [13:0]               conversion_setup_word,
  output cfg_pkg::setup_ctrl_t      ctrl,
  // readback frame for the result shifter
  output logic [27:0]               readout_frame,
  output logic [4:0]                readout_bits
);

  // ==========================================================
  // link domain: shift register, bit counter, word toggle
  logic [13:0] shift_q, shift_d;
  logic [4:0]  cnt_q,   cnt_d;
  logic [13:0] hold_q,  hold_d;
  logic        tog_q,   tog_d;
  // cs_n only clears the counter here, so it needs no synchroniser

  // the counter holds at fourteen bits; cs_n high async-clears it
  always_comb begin
    shift_d = {shift_q[12:0], din};
    cnt_d   = cnt_q;
    hold_d  = hold_q;
    tog_d   = tog_q;
    if (cnt_q < cfg_pkg::BITCNT_FULL) begin
      cnt_d = cnt_q + 5'h01;
    end
    // fourteenth bit lands: hand complete word across
    if (cnt_q == cfg_pkg::BITCNT_FULL - 5'h01) begin
      hold_d = {shift_q[12:0], din};
      tog_d  = ~tog_q;
    end
  end

  // cs_n high ends the frame without needing an sclk edge
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      cnt_q <= cfg_pkg::BITCNT_ZERO;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge sclk or negedge arst_n) begin
    if (!arst_n) begin
      shift_q <= '0;
      hold_q  <= '0;
      tog_q   <= 1'b0;
    end else begin
      shift_q <= shift_d;
      hold_q  <= hold_d;
      tog_q   <= tog_d;
    end
  end

  // ==========================================================
  // clk domain: toggle sync, pending word, apply at eoc
  logic [2:0]  tsync_q, tsync_d;
  logic [13:0] pend_q,  pend_d;
  logic        pval_q,  pval_d;
  logic [13:0] word_q,  word_d;
  logic        new_word;

  assign new_word = tsync_q[2] ^ tsync_q[1];

  // hold_q is stable for a whole frame after the toggle, so it is
  // safe to sample once the toggle has crossed two flops
  always_comb begin
    tsync_d = {tsync_q[1:0], tog_q};
    pend_d  = pend_q;
    pval_d  = pval_q;
    word_d  = word_q;
    if (new_word) begin
      pend_d = hold_q;
      pval_d = 1'b1;
    end
    if (eoc) begin
      // only words completed before eoc count; a word still
      // shifting waits for the next eoc because its toggle has not arrived
      pval_d = new_word;
      if (pval_q && pend_q[cfg_pkg::UPDATE_BIT]) begin
        word_d = pend_q;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tsync_q <= '0;
      pend_q  <= '0;
      pval_q  <= 1'b0;
      word_q  <= cfg_pkg::WORD_RESET;
    end else begin
      tsync_q <= tsync_d;
      pend_q  <= pend_d;
      pval_q  <= pval_d;
      word_q  <= word_d;
    end
  end

  assign conversion_setup_word = word_q;

  // ==========================================================
  // field decode
  cfg_pkg::ref_code_t  ref_code;
  cfg_pkg::scan_mode_t scan_code;
  cfg_pkg::setup_ctrl_t ctrl_d, ctrl_q;

  assign ref_code  = cfg_pkg::ref_code_t'(
    word_q[cfg_pkg::REF_LSB +: cfg_pkg::REF_W]);
  assign scan_code = cfg_pkg::scan_mode_t'(
    word_q[cfg_pkg::SEQ_LSB +: cfg_pkg::SEQ_W]);

  always_comb begin
    ctrl_d = '0;
    ctrl_d.channel_select_field =
      word_q[cfg_pkg::CHAN_LSB +: cfg_pkg::CHAN_W];
    ctrl_d.full_bandwidth = word_q[cfg_pkg::BW_BIT];
    // reserved codes leave all reference controls off
    unique case (ref_code)
      cfg_pkg::REF_INT_2V5: begin
        ctrl_d.int_ref_en = 1'b1;
        ctrl_d.ref_buffer_en = 1'b1;
      end
      cfg_pkg::REF_INT_4V096: begin
        ctrl_d.int_ref_en    = 1'b1;
        ctrl_d.int_ref_4v096 = 1'b1;
        ctrl_d.ref_buffer_en = 1'b1;
      end
      cfg_pkg::REF_EXT_TEMP: begin
        ctrl_d.temp_sensor_en = 1'b1;
      end
      cfg_pkg::REF_EXTBUF_TMP: begin
        ctrl_d.ref_buffer_en  = 1'b1;
        ctrl_d.temp_sensor_en = 1'b1;
      end
      cfg_pkg::REF_EXT: begin
        ctrl_d.temp_sensor_en = 1'b0;
      end
      cfg_pkg::REF_EXTBUF: begin
        ctrl_d.ref_buffer_en = 1'b1;
      end
      cfg_pkg::REF_RSV_100,
      cfg_pkg::REF_RSV_101: begin
        ctrl_d.ref_code_reserved = 1'b1;
      end
    endcase
    unique case (scan_code)
      cfg_pkg::SCAN_OFF: begin
        ctrl_d.scan_en = 1'b0;
      end
      cfg_pkg::SCAN_UPDATE: begin
        ctrl_d.scan_update_only = 1'b1;
      end
      cfg_pkg::SCAN_WITH_TEMP: begin
        ctrl_d.scan_en   = 1'b1;
        ctrl_d.scan_temp = 1'b1;
      end
      cfg_pkg::SCAN_NO_TEMP: begin
        ctrl_d.scan_en = 1'b1;
      end
    endcase
    ctrl_d.setup_readback_en = ~word_q[cfg_pkg::RB_BIT];
  end

  // readout frame: result then, when enabled, the setup word
  logic [27:0] frame_d, frame_q;
  logic [4:0]  bits_d,  bits_q;

  always_comb begin
    if (ctrl_d.setup_readback_en) begin
      frame_d = {result, word_q};
      bits_d  = 5'h1c;
    end else begin
      frame_d = {result, 14'h0000};
      bits_d  = 5'h0e;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q  <= '0;
      frame_q <= '0;
      bits_q  <= cfg_pkg::BITCNT_FULL;
    end else begin
      ctrl_q  <= ctrl_d;
      frame_q <= frame_d;
      bits_q  <= bits_d;
    end
  end

  assign ctrl          = ctrl_q;
  assign readout_frame = frame_q;
  assign readout_bits  = bits_q;

endmodule : adc_config_field_decoder

// ### bench/cfg_decoder_chk_sva.sv
// checker for the setup word decoder
// assumes it is bound to the decoder top module
`timescale 1ns/1ps
module cfg_decoder_chk (
  // clock and reset
  input wire logic                 clk,
  input wire logic                 arst_n,
  // watched ports
  input wire logic                 eoc,
  input wire logic [13:0]          result,
  input wire logic [13:0]          conversion_setup_word,
  input wire cfg_pkg::setup_ctrl_t ctrl,
  input wire logic [27:0]          readout_frame,
  input wire logic [4:0]           readout_bits
);
  // =====
  // decode lags the applied word by one clk
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic [13:0] w;
  assign w = conversion_setup_word;
  // the first edge after release still shows the reset decode, so the
  // lagging outputs are only compared once the previous edge was live
  bw_map_a: assert property (
    $past(arst_n) |-> ctrl.full_bandwidth == $past(w[6]))
    else $error("bandwidth wrong");
  chan_map_a: assert property (
    $past(arst_n) |-> ctrl.channel_select_field == $past(w[9:7]))
    else $error("channel wrong");
  int_ref_a: assert property (
    $past(arst_n) && $past(w[5:4]) == 2'b00 |-> ctrl.int_ref_en &&
    !ctrl.temp_sensor_en && ctrl.int_ref_4v096 == $past(w[3]))
    else $error("internal ref wrong");
  ext_ref_a: assert property (
    $past(arst_n) && $past(w[4]) |-> !ctrl.int_ref_en &&
    ctrl.ref_buffer_en == $past(w[3]) &&
    ctrl.temp_sensor_en == !$past(w[5]))
    else $error("external ref wrong");
  scan_mode_a: assert property (
    $past(arst_n) |-> ctrl.scan_temp == ($past(w[2:1]) == 2'b10) &&
    ctrl.scan_update_only == ($past(w[2:1]) == 2'b01))
    else $error("scan mode wrong");
  rb_count_a: assert property (
    $past(arst_n) |-> readout_bits == ($past(w[0]) ? 5'h0e : 5'h1c))
    else $error("bits wrong");
  rb_frame_a: assert property (
    $past(arst_n) |->
    readout_frame == {$past(result), $past(w[0]) ? 14'h0000 : $past(w)})
    else $error("frame wrong");
  word_hold_a: assert property (
    !$past(eoc) |-> $stable(w)) else $error("word moved off eoc");
  upd_bit_a: assert property (
    $changed(w) |-> w[13]) else $error("word applied without top bit");
endmodule : cfg_decoder_chk
bind adc_config_field_decoder cfg_decoder_chk i_chk (.clk(clk),
  .arst_n(arst_n), .eoc(eoc), .result(result), .ctrl(ctrl),
  .conversion_setup_word(conversion_setup_word),
  .readout_frame(readout_frame), .readout_bits(readout_bits));

// ### bench/host_link.sv
// host model driving the serial setup link
// assumes the bench calls send between conversions
`timescale 1ns/1ps
module host_link (
  // serial link
  output logic sclk,
  output logic cs_n,
  output logic din
);
  // =====
  // sclk stands low between frames, 12 ns period
  initial begin
    sclk = 1'b0;
    cs_n = 1'b0;
    din  = 1'b0;
    // rise after time zero so the async counter clear sees a real edge
    #1 cs_n = 1'b1;
  end
  task automatic send(input logic [13:0] w, input int n);
    cs_n = 1'b0;
    for (int i = 13; i > 13 - n; i--) begin
      din = w[i];
      #6 sclk = 1'b1;
      #6 sclk = 1'b0;
    end
    #6 cs_n = 1'b1;
    din = ~din; // released line must not hold a stale bit
  endtask : send
endmodule : host_link

// ### bench/adc_config_field_decoder_bench.sv
// bench for the setup word decoder
// assumes host model and checker are compiled first
`timescale 1ns/1ps
module adc_config_field_decoder_bench;
  logic                 clk, arst_n, eoc, sclk, cs_n, din;
  logic [13:0]          result, word, last;
  cfg_pkg::setup_ctrl_t ctrl;
  logic [27:0]          frame;
  logic [4:0]           bits;
  int                   err_total, n_checks;
  logic [2:0]           refs [8] = '{0, 1, 2, 3, 6, 7, 2, 6};
  adc_config_field_decoder i_adc_config_field_decoder (.clk(clk),
    .arst_n(arst_n), .sclk(sclk), .cs_n(cs_n), .din(din), .eoc(eoc),
    .result(result), .conversion_setup_word(word), .ctrl(ctrl),
    .readout_frame(frame), .readout_bits(bits));
  host_link i_host_link (.sclk(sclk), .cs_n(cs_n), .din(din));
  // =====
  initial clk = 1'b0;
  always #2.5 clk = ~clk;
  task automatic chk_word(input logic [13:0] exp);
    n_checks++;
    if (word !== exp) begin
      err_total++;
      $display("[ERR] %0t word %h exp %h", $time, word, exp);
    end
  endtask : chk_word
  task automatic chk_bits(input logic [4:0] exp);
    n_checks++;
    if (bits !== exp) begin
      err_total++;
      $display("[ERR] %0t bits %0d exp %0d", $time, bits, exp);
    end
  endtask : chk_bits
  // end of conversion, spaced well past the last sclk edge; the slow
  // pace also keeps quarter bandwidth words within their rate limit
  task automatic fin(input logic [13:0] exp);
    repeat (6) @(posedge clk);
    result <= result + 14'h0111;
    eoc    <= 1'b1;
    @(posedge clk);
    eoc <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk_word(exp);
    chk_bits(exp[0] ? 5'h0e : 5'h1c);
  endtask : fin
  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : give_verdict
  initial begin
    err_total = 0;
    n_checks  = 0;
    arst_n    = 1'b1;
    eoc       = 1'b0;
    result    = 14'h1234;
    // a real falling edge after time zero, so no flop misses reset
    #1 arst_n = 1'b0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk_word(14'h3fff);
    chk_bits(5'h0e);
    for (int k = 0; k < 8; k++) begin
      last = {1'b1, 3'b101, 3'(k), k[0], refs[k], 2'(k), k[1]};
      i_host_link.send(last, 14);
      fin(last);
    end
    i_host_link.send(14'h1fff, 14);
    fin(last);
    i_host_link.send(14'h2000, 7);
    fin(last);
    i_host_link.send(14'h2000, 14);
    repeat (8) @(posedge clk);
    #1 chk_word(last);
    fin(14'h2000);
    give_verdict();
  end
  initial begin
    #200000;
    err_total++;
    give_verdict();
  end
endmodule : adc_config_field_decoder_bench
